/* File: include/sppci_pkg.sv */
/*
 * Shared constants for the second general-purpose port block:
 * register offsets, reset values, field positions and widths.
 * Assumes an 8-bit register port with 8-bit offsets from the core.
 */
package sppci_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int SPPCI_PINS = 8;
	localparam int SPPCI_AW = 8;
	localparam int SPPCI_DW = 8;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] SPPCI_OFS_PORT_DATA = 8'h06;
	localparam logic [7:0] SPPCI_OFS_IRQ_CONTROL = 8'h0B;
	localparam logic [7:0] SPPCI_OFS_OPTION = 8'h81;
	localparam logic [7:0] SPPCI_OFS_DIRECTION = 8'h86;
	localparam logic [7:0] SPPCI_OFS_PULLUP_SEL = 8'h95;
	localparam logic [7:0] SPPCI_OFS_CHANGE_SEL = 8'h96;
	localparam logic [7:0] SPPCI_OFS_ANALOG_SEL = 8'h9D;

	////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [7:0] SPPCI_RST_LATCH = 8'h00;
	localparam logic [7:0] SPPCI_RST_OPTION = 8'hFF;
	localparam logic [7:0] SPPCI_RST_DIRECTION = 8'hFF;
	localparam logic [7:0] SPPCI_RST_PULLUP_SEL = 8'hFF;
	localparam logic [7:0] SPPCI_RST_CHANGE_SEL = 8'hF0;
	localparam logic [7:0] SPPCI_RST_ANALOG_SEL = 8'h3F;
	localparam logic [7:0] SPPCI_RST_SNAPSHOT = 8'h03;
	localparam logic SPPCI_RST_IE = 1'b0;
	localparam logic SPPCI_RST_GIE = 1'b0;
	localparam logic SPPCI_RST_FLAG = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Field positions and masks
	localparam int SPPCI_BIT_PU_GLOBAL_OFF_N = 7;
	localparam int SPPCI_BIT_FLAG = 0;
	localparam int SPPCI_BIT_IE = 3;
	localparam int SPPCI_BIT_GIE = 7;
	localparam int SPPCI_BIT_ANA_PIN0 = 4;
	localparam int SPPCI_BIT_ANA_PIN1 = 5;
	localparam logic [7:0] SPPCI_ANALOG_MASK = 8'h3F;

endpackage : sppci_pkg

/* File: src/sppci_pin_slice.sv */
/*
 * One port pin: output driver enable, weak pull-up gating, digital
 * input buffer and the change comparison against the snapshot bit.
 * Assumes the pad resolves the wire from PIN_OE_N and the pull-up.
 */
`timescale 1ns/1ns
module sppci_pin_slice
	import sppci_pkg::*;
(
	// Configuration
	input wire logic dir_in,
	input wire logic latch,
	input wire logic pu_sel,
	input wire logic pu_global_off_n,
	input wire logic analog,
	input wire logic chg_sel,
	input wire logic snap,
	// Pad
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n,
	output logic pullup_en,
	// To the core side
	output logic din,
	output logic mismatch
);

	////////////////////////////////////////////////////////////////////////
	// Driver: high impedance while an input, latch on the pin otherwise
	assign pin_oe_n = dir_in;
	assign pin_out = latch;

	// Pull-up needs its select, the global enable low and input mode
	assign pullup_en = pu_sel & ~pu_global_off_n & dir_in;

	// Analog pins have no digital buffer, so they read as a constant one
	assign din = analog ? 1'b1 : pin_in;

	// Only selected inputs take part in change detection
	assign mismatch = chg_sel & dir_in & (din ^ snap);

endmodule : sppci_pin_slice

/* File: src/sppci_change_flag.sv */
/*
 * Port-change flag: ORs the per-pin mismatches into a sticky flag and
 * gates it onto the interrupt request and the sleep wake request.
 * Assumes the clear and set requests are one-cycle register writes.
 */
`timescale 1ns/1ns
module sppci_change_flag
	import sppci_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Events and controls
	input wire logic [SPPCI_PINS-1:0] mismatch,
	input wire logic set_req,
	input wire logic clr_req,
	input wire logic irq_en,
	input wire logic global_irq_enable,
	// Results
	output logic flag,
	output logic irq,
	output logic wake
);

	logic any_mismatch;
	logic next_flag;

	////////////////////////////////////////////////////////////////////////
	// Sticky flag; a standing mismatch beats a clear in the same cycle
	assign any_mismatch = |mismatch;
	always_comb begin
		next_flag = any_mismatch | set_req | (flag & ~clr_req);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag <= SPPCI_RST_FLAG;
		end else begin
			flag <= next_flag;
		end
	end

	// Interrupt needs both enables; wake ignores the global enable
	assign irq = flag & irq_en & global_irq_enable;
	assign wake = flag & irq_en;

	////////////////////////////////////////////////////////////////////////
	// Checks
	flag_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
		any_mismatch |=> flag)
		else $error("mismatch did not set the change flag");

	clear_blocked_a: assert property (@(posedge clk) disable iff (!rst_n)
		(clr_req && any_mismatch) |=> flag)
		else $error("clear won over a standing mismatch");

	flag_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
		(flag && !clr_req) |=> flag)
		else $error("change flag dropped without a clear");

	irq_gated_a: assert property (@(posedge clk) disable iff (!rst_n)
		irq |-> (flag && irq_en && global_irq_enable))
		else $error("interrupt raised without both enables");

	// The enable may be rewritten in the same cycle, so compare with its new value
	wake_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
		any_mismatch |=> (wake == irq_en))
		else $error("wake request missing after a change");

endmodule : sppci_change_flag

/* File: src/sppci_top.sv */
/*
 * Second general-purpose port: register file on a plain strobe port,
 * eight pin slices, the change snapshot and the port-change flag.
 * Assumes one-cycle read and write strobes, never both at once, and
 * board pins already synchronous to SYS_CLK.
 */
`timescale 1ns/1ns

// Behaviour
// - Direction bit one puts the pin driver into high impedance.
// - Direction bit zero drives the pin from its output latch.
// - Each pin has a pull-up select bit; one enables, zero disables.
// - Pull-up selects act only while option bit 7 is cleared.
// - A pin in output mode always has its pull-up off.
// - After reset all weak pull-ups are off.
// - Only input pins with their change select set are compared.
// - Mismatches against the snapshot are ORed into irq_control bit 0.
// - Any read or write of the port data refreshes the snapshot.
// - A lasting mismatch keeps setting the flag; software accesses, then clears.
// - The interrupt needs both the change enable and the global enable.
// - The port-change event can wake the device from sleep.
// - Pins 0 and 1 are analog after reset and read as one.
// - An analog pin has its digital input buffer switched off.
module sppci_top
	import sppci_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [SPPCI_AW-1:0] ADDR,
	input wire logic [SPPCI_DW-1:0] WR_DATA,
	input wire logic WR_STROBE,
	input wire logic RD_STROBE,
	output logic [SPPCI_DW-1:0] RD_DATA,
	// Port pins
	input wire logic [SPPCI_PINS-1:0] PIN_IN,
	output logic [SPPCI_PINS-1:0] PIN_OUT,
	output logic [SPPCI_PINS-1:0] PIN_OE_N,
	output logic [SPPCI_PINS-1:0] PULLUP_EN,
	// Events to the core
	output logic CHANGE_IRQ,
	output logic WAKE_REQ
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0] latch;
	logic [7:0] option_cfg;
	logic [7:0] direction;
	logic [7:0] pullup_sel;
	logic [7:0] change_sel;
	logic [7:0] analog_sel;
	logic [7:0] snapshot;
	logic irq_en;
	logic global_irq_enable;
	logic [7:0] next_latch;
	logic [7:0] next_option_cfg;
	logic [7:0] next_direction;
	logic [7:0] next_pullup_sel;
	logic [7:0] next_change_sel;
	logic [7:0] next_analog_sel;
	logic [7:0] next_snapshot;
	logic next_irq_en;
	logic next_gie;
	logic [7:0] next_rd_data;
	logic [7:0] din;
	logic [7:0] mismatch;
	logic [7:0] analog_pins;
	logic flag;
	logic wr_port;
	logic rd_port;
	logic wr_irqc;
	logic flag_set_req;
	logic flag_clr_req;

	////////////////////////////////////////////////////////////////////////
	// Strobe decode
	assign wr_port = WR_STROBE && (ADDR == SPPCI_OFS_PORT_DATA);
	assign rd_port = RD_STROBE && (ADDR == SPPCI_OFS_PORT_DATA);
	assign wr_irqc = WR_STROBE && (ADDR == SPPCI_OFS_IRQ_CONTROL);

	// Writing one sets the flag by software, writing zero asks to clear
	assign flag_set_req = wr_irqc && WR_DATA[SPPCI_BIT_FLAG];
	assign flag_clr_req = wr_irqc && !WR_DATA[SPPCI_BIT_FLAG];

	////////////////////////////////////////////////////////////////////////
	// Register file next values
	always_comb begin
		next_latch = latch;
		next_option_cfg = option_cfg;
		next_direction = direction;
		next_pullup_sel = pullup_sel;
		next_change_sel = change_sel;
		next_analog_sel = analog_sel;
		next_irq_en = irq_en;
		next_gie = global_irq_enable;
		if (WR_STROBE) begin
			unique case (ADDR)
				// A full byte store; bit operations in the core merge pins first
				SPPCI_OFS_PORT_DATA: next_latch = WR_DATA;
				SPPCI_OFS_OPTION: next_option_cfg = WR_DATA;
				SPPCI_OFS_DIRECTION: next_direction = WR_DATA;
				SPPCI_OFS_PULLUP_SEL: next_pullup_sel = WR_DATA;
				SPPCI_OFS_CHANGE_SEL: next_change_sel = WR_DATA;
				SPPCI_OFS_ANALOG_SEL: next_analog_sel = WR_DATA & SPPCI_ANALOG_MASK;
				SPPCI_OFS_IRQ_CONTROL: begin
					next_irq_en = WR_DATA[SPPCI_BIT_IE];
					next_gie = WR_DATA[SPPCI_BIT_GIE];
				end
				default: begin
				end
			endcase
		end
	end

	// Register file storage; option bit 7 resets high, so pull-ups start off
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			latch <= SPPCI_RST_LATCH;
			option_cfg <= SPPCI_RST_OPTION;
			direction <= SPPCI_RST_DIRECTION;
			pullup_sel <= SPPCI_RST_PULLUP_SEL;
			change_sel <= SPPCI_RST_CHANGE_SEL;
			analog_sel <= SPPCI_RST_ANALOG_SEL;
			irq_en <= SPPCI_RST_IE;
			global_irq_enable <= SPPCI_RST_GIE;
		end else begin
			latch <= next_latch;
			option_cfg <= next_option_cfg;
			direction <= next_direction;
			pullup_sel <= next_pullup_sel;
			change_sel <= next_change_sel;
			analog_sel <= next_analog_sel;
			irq_en <= next_irq_en;
			global_irq_enable <= next_gie;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Change snapshot: any port access catches the current pin levels.
	// Polling the port therefore hides changes; that is inherent.
	always_comb begin
		next_snapshot = snapshot;
		if (wr_port || rd_port) begin
			next_snapshot = din;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			snapshot <= SPPCI_RST_SNAPSHOT;
		end else begin
			snapshot <= next_snapshot;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, present only in the cycle after the strobe
	always_comb begin
		next_rd_data = 8'h00;
		if (RD_STROBE) begin
			unique case (ADDR)
				SPPCI_OFS_PORT_DATA: next_rd_data = din;
				SPPCI_OFS_OPTION: next_rd_data = option_cfg;
				SPPCI_OFS_DIRECTION: next_rd_data = direction;
				SPPCI_OFS_PULLUP_SEL: next_rd_data = pullup_sel;
				SPPCI_OFS_CHANGE_SEL: next_rd_data = change_sel;
				SPPCI_OFS_ANALOG_SEL: next_rd_data = analog_sel;
				SPPCI_OFS_IRQ_CONTROL: begin
					next_rd_data[SPPCI_BIT_GIE] = global_irq_enable;
					next_rd_data[SPPCI_BIT_IE] = irq_en;
					next_rd_data[SPPCI_BIT_FLAG] = flag;
				end
				default: next_rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			RD_DATA <= 8'h00;
		end else begin
			RD_DATA <= next_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin slices; only pins 0 and 1 have an analog function
	assign analog_pins = {6'h00, analog_sel[SPPCI_BIT_ANA_PIN1],
		analog_sel[SPPCI_BIT_ANA_PIN0]};

	for (genvar i = 0; i < SPPCI_PINS; i++) begin : g_pin
		sppci_pin_slice u_pin (
			.dir_in(direction[i]),
			.latch(latch[i]),
			.pu_sel(pullup_sel[i]),
			.pu_global_off_n(option_cfg[SPPCI_BIT_PU_GLOBAL_OFF_N]),
			.analog(analog_pins[i]),
			.chg_sel(change_sel[i]),
			.snap(snapshot[i]),
			.pin_in(PIN_IN[i]),
			.pin_out(PIN_OUT[i]),
			.pin_oe_n(PIN_OE_N[i]),
			.pullup_en(PULLUP_EN[i]),
			.din(din[i]),
			.mismatch(mismatch[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Port-change flag and event outputs
	sppci_change_flag u_flag (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.mismatch(mismatch),
		.set_req(flag_set_req),
		.clr_req(flag_clr_req),
		.irq_en(irq_en),
		.global_irq_enable(global_irq_enable),
		.flag(flag),
		.irq(CHANGE_IRQ),
		.wake(WAKE_REQ)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence port_access_s;
		(wr_port || rd_port);
	endsequence

	sequence pins_steady_s;
		($stable(PIN_IN) && $stable(direction) && $stable(analog_sel) && !WR_STROBE);
	endsequence

	dir_hiz_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(WR_STROBE && ADDR == SPPCI_OFS_DIRECTION) |=> (PIN_OE_N == $past(WR_DATA)))
		else $error("output enable does not follow direction write");

	drive_latch_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		wr_port |=> (PIN_OUT == $past(WR_DATA)))
		else $error("pin output does not follow latch write");

	pullup_sel_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(WR_STROBE && ADDR == SPPCI_OFS_PULLUP_SEL && direction == 8'hFF
		&& !option_cfg[SPPCI_BIT_PU_GLOBAL_OFF_N]) |=> (PULLUP_EN == $past(WR_DATA)))
		else $error("pull-up enables do not follow select write");

	pullup_global_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(WR_STROBE && ADDR == SPPCI_OFS_OPTION && WR_DATA[SPPCI_BIT_PU_GLOBAL_OFF_N])
		|=> (PULLUP_EN == 8'h00))
		else $error("pull-up on while global disable set");

	pullup_output_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(PULLUP_EN & ~PIN_OE_N) == 8'h00)
		else $error("pull-up on for a driven pin");

	pullup_reset_a: assert property (@(posedge SYS_CLK)
		$rose(RST_N) |-> (PULLUP_EN == 8'h00))
		else $error("pull-up on right after reset");

	change_select_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(mismatch & ~(change_sel & direction)) == 8'h00)
		else $error("unselected or output pin compared");

	snapshot_ends_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		port_access_s ##1 pins_steady_s |-> (mismatch == 8'h00))
		else $error("port access did not end the mismatch");

	analog_reads_one_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(rd_port && analog_sel[5:4] == 2'b11) |=> (RD_DATA[1:0] == 2'b11))
		else $error("analog pins did not read as one");

	read_single_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		rd_port |=> (RD_DATA == $past(din)) ##1 ($past(RD_STROBE) || RD_DATA == 8'h00))
		else $error("port read data wrong or held too long");

	// The snapshot takes the pin levels seen with the access
	snapshot_load_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		port_access_s |=> (snapshot == $past(din)))
		else $error("snapshot not loaded by port access");

	// Both analog pins come out of reset analog, so their buffers start off
	analog_reset_a: assert property (@(posedge SYS_CLK)
		$rose(RST_N) |-> (analog_sel[SPPCI_BIT_ANA_PIN1] && analog_sel[SPPCI_BIT_ANA_PIN0]))
		else $error("analog pins not selected after reset");

	// A pin with its buffer off feeds a constant one to the core
	buffer_off_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(analog_sel[SPPCI_BIT_ANA_PIN1] && analog_sel[SPPCI_BIT_ANA_PIN0])
		|-> (din[1:0] == 2'b11))
		else $error("analog pin fed the digital logic");

	// Both enables are taken from the written byte
	irq_enables_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		wr_irqc |=> (irq_en == $past(WR_DATA[SPPCI_BIT_IE])
		&& global_irq_enable == $past(WR_DATA[SPPCI_BIT_GIE])))
		else $error("interrupt enables not written");

	// Without a read strobe the read port rests at zero
	read_idle_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!RD_STROBE |=> (RD_DATA == 8'h00))
		else $error("read data present without a read");

endmodule : sppci_top

/* File: test/sppci_board.sv */
/*
 * Board model for the second port: resolves each pin wire from the
 * block's drive, the weak pull-up and the board's own drivers.
 * Assumes PIN_OE_N low means the block drives that pin.
 */
`timescale 1ns/1ns
module sppci_board
	import sppci_pkg::*;
(
	// Clock
	input wire logic clk,
	// Block side
	input wire logic [SPPCI_PINS-1:0] pin_out,
	input wire logic [SPPCI_PINS-1:0] pin_oe_n,
	input wire logic [SPPCI_PINS-1:0] pullup_en,
	// Board drivers
	input wire logic [SPPCI_PINS-1:0] drv_val,
	input wire logic [SPPCI_PINS-1:0] drv_en,
	// Wire level seen by the block
	output logic [SPPCI_PINS-1:0] pin_in
);
	logic [SPPCI_PINS-1:0] last;

	////////////////////////////////////////////////////////////////////////
	// A floating pin shows the inverse of its last level, so a missing
	// pull-up can never pass by luck of the simulator
	always_comb begin
		for (int i = 0; i < SPPCI_PINS; i++) begin
			if (!pin_oe_n[i])
				pin_in[i] = pin_out[i];
			else if (drv_en[i])
				pin_in[i] = drv_val[i];
			else if (pullup_en[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = ~last[i];
		end
	end

	// Remember the wire for the floating case
	always_ff @(posedge clk) begin
		last <= pin_in;
	end
endmodule : sppci_board

/* File: test/test_sppci_top.sv */
/*
 * Self-checking bench for the second port block: register reset
 * values, pin drive, pull-ups, analog pins and change detection.
 * Assumes the board model in sppci_board and a 10 MHz clock.
 */
`timescale 1ns/1ns
module test_sppci_top;
	import sppci_pkg::*;

	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [7:0] WR_DATA = 8'h00;
	logic WR_STROBE = 1'b0;
	logic RD_STROBE = 1'b0;
	logic [7:0] RD_DATA;
	logic [7:0] PIN_IN;
	logic [7:0] PIN_OUT;
	logic [7:0] PIN_OE_N;
	logic [7:0] PULLUP_EN;
	logic CHANGE_IRQ;
	logic WAKE_REQ;
	logic [7:0] drv_val = 8'h00;
	logic [7:0] drv_en = 8'hFF;
	logic [7:0] rd_val;
	int fails = 0;
	int comparisons = 0;

	////////////////////////////////////////////////////////////////////////
	// Clock, block and board
	always #50 SYS_CLK = ~SYS_CLK;

	sppci_top DUT (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
		.WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE), .RD_DATA(RD_DATA), .PIN_IN(PIN_IN),
		.PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .PULLUP_EN(PULLUP_EN),
		.CHANGE_IRQ(CHANGE_IRQ), .WAKE_REQ(WAKE_REQ));

	sppci_board board (.clk(SYS_CLK), .pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N),
		.pullup_en(PULLUP_EN), .drv_val(drv_val), .drv_en(drv_en), .pin_in(PIN_IN));

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	// One-cycle write; effect is settled on return
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		WR_STROBE <= 1'b1;
		ADDR <= a;
		WR_DATA <= d;
		@(posedge SYS_CLK);
		WR_STROBE <= 1'b0;
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge SYS_CLK);
		RD_STROBE <= 1'b1;
		ADDR <= a;
		@(posedge SYS_CLK);
		RD_STROBE <= 1'b0;
		#1;
		rd_val = RD_DATA;
	endtask : rd

	task automatic stop_test;
		$display("comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_reset;
		logic [7:0] adr [0:7] = '{8'h06, 8'h0B, 8'h81, 8'h86, 8'h95, 8'h96, 8'h9D, 8'h10};
		logic [7:0] exp [0:7] = '{8'h03, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hF0, 8'h3F, 8'h00};
		check("pullups after reset", PULLUP_EN, 8'h00);
		check("drivers after reset", PIN_OE_N, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			rd(adr[i]);
			check("reset register", rd_val, exp[i]);
		end
		$display("test_reset done");
	endtask : test_reset

	task automatic test_pins;
		wr(SPPCI_OFS_DIRECTION, 8'h0F);
		wr(SPPCI_OFS_PORT_DATA, 8'hA5);
		@(posedge SYS_CLK) drv_val <= 8'h08;
		check("pin drive enable", PIN_OE_N, 8'h0F);
		check("pin drive value", PIN_OUT, 8'hA5);
		rd(SPPCI_OFS_PORT_DATA);
		check("port levels", rd_val, 8'hAB);
		$display("test_pins done");
	endtask : test_pins

	task automatic test_pullup;
		wr(SPPCI_OFS_OPTION, 8'h7F);
		wr(SPPCI_OFS_PULLUP_SEL, 8'h55);
		check("pullups gated", PULLUP_EN, 8'h05);
		@(posedge SYS_CLK) drv_en <= 8'hFB;
		rd(SPPCI_OFS_PORT_DATA);
		check("pulled pin level", rd_val, 8'hAF);
		@(posedge SYS_CLK) drv_en <= 8'hFF;
		wr(SPPCI_OFS_OPTION, 8'hFF);
		check("pullups global off", PULLUP_EN, 8'h00);
		$display("test_pullup done");
	endtask : test_pullup

	task automatic test_analog;
		wr(SPPCI_OFS_DIRECTION, 8'hFF);
		@(posedge SYS_CLK) drv_val <= 8'h00;
		wr(SPPCI_OFS_ANALOG_SEL, 8'hFF);
		rd(SPPCI_OFS_ANALOG_SEL);
		check("analog select mask", rd_val, 8'h3F);
		wr(SPPCI_OFS_ANALOG_SEL, 8'h00);
		rd(SPPCI_OFS_PORT_DATA);
		check("digital pins 1:0", rd_val, 8'h00);
		wr(SPPCI_OFS_ANALOG_SEL, 8'h30);
		wr(SPPCI_OFS_OPTION, 8'h7F);
		wr(SPPCI_OFS_PULLUP_SEL, 8'hAA);
		check("pullups on inputs", PULLUP_EN, 8'hAA);
		wr(SPPCI_OFS_OPTION, 8'hFF);
		check("pullups off again", PULLUP_EN, 8'h00);
		$display("test_analog done");
	endtask : test_analog

	// A clear during the mismatch is blocked; software then accesses the port and clears, as intended for wake-up use
	task automatic test_change;
		wr(SPPCI_OFS_IRQ_CONTROL, 8'h88);
		rd(SPPCI_OFS_PORT_DATA);
		check("snapshot read", rd_val, 8'h03);
		@(posedge SYS_CLK) drv_val <= 8'h04;
		@(posedge SYS_CLK);
		#1;
		check("unselected pin", {7'h00, CHANGE_IRQ}, 8'h00);
		@(posedge SYS_CLK) drv_val <= 8'h14;
		@(posedge SYS_CLK);
		#1;
		check("change irq", {6'h00, WAKE_REQ, CHANGE_IRQ}, 8'h03);
		wr(SPPCI_OFS_IRQ_CONTROL, 8'h88);
		rd(SPPCI_OFS_IRQ_CONTROL);
		check("clear during mismatch", rd_val, 8'h89);
		rd(SPPCI_OFS_PORT_DATA);
		check("port after change", rd_val, 8'h17);
		wr(SPPCI_OFS_IRQ_CONTROL, 8'h88);
		rd(SPPCI_OFS_IRQ_CONTROL);
		check("flag cleared", rd_val, 8'h88);
		check("irq dropped", {7'h00, CHANGE_IRQ}, 8'h00);
		wr(SPPCI_OFS_IRQ_CONTROL, 8'h08);
		@(posedge SYS_CLK) drv_val <= 8'h34;
		@(posedge SYS_CLK);
		#1;
		check("wake without gie", {6'h00, WAKE_REQ, CHANGE_IRQ}, 8'h02);
		rd(SPPCI_OFS_IRQ_CONTROL);
		check("flag without gie", rd_val, 8'h09);
		$display("test_change done");
	endtask : test_change

	////////////////////////////////////////////////////////////////////////
	// Main sequence and hang guard
	initial begin
		repeat (12) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		#1;
		test_reset();
		test_pins();
		test_pullup();
		test_analog();
		test_change();
		stop_test();
	end

	initial begin
		#2000000;
		fails++;
		stop_test();
	end
endmodule : test_sppci_top
